// File: logic/dmas_params.svh
`ifndef DMAS_PARAMS_SVH
`define DMAS_PARAMS_SVH

// ==========================================================
// register byte offsets
`define DMAS_OFS_CTRL      8'h00
`define DMAS_OFS_SEL       8'h04
`define DMAS_OFS_RESULT    8'h08
`define DMAS_OFS_COUNT     8'h0C

// ==========================================================
// control register fields
`define DMAS_CTRL_IN_EN    0
`define DMAS_CTRL_PIPE_EN  1
`define DMAS_CTRL_OUT_EN   2
`define DMAS_CTRL_SUB0     3
`define DMAS_CTRL_SUB1     4
`define DMAS_CTRL_W        5

// ==========================================================
// select register fields, one byte per stage
`define DMAS_SEL_IN_LSB    0
`define DMAS_SEL_PIPE_LSB  8
`define DMAS_SEL_OUT_LSB   16
`define DMAS_SEL_CLK_OFS   0
`define DMAS_SEL_CE_OFS    2
`define DMAS_SEL_RST_OFS   4
`define DMAS_SEL_W         24

// ==========================================================
// reset values and sizes
`define DMAS_CTRL_RST      5'h00
`define DMAS_SEL_RST       24'h000000
`define DMAS_OP_W_DEF      9
`define DMAS_COUNT_W       16
`define DMAS_NSRC          4

`endif

// File: logic/dmas_pkg.sv
package dmas_pkg;

	typedef logic [1:0] dmas_sel_t;

	typedef enum logic {
		DMAS_ADD = 1'b0,
		DMAS_SUB = 1'b1
	} dmas_op_e;

endpackage

// File: logic/dmas_stage_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmas_params.svh"

module dmas_stage_sel
	import dmas_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic [`DMAS_NSRC-1:0] clk_src,
	input  wire logic [`DMAS_NSRC-1:0] ce_src,
	input  wire logic [`DMAS_NSRC-1:0] rst_src,
	input  wire dmas_sel_t             clk_sel,
	input  wire dmas_sel_t             ce_sel,
	input  wire dmas_sel_t             rst_sel,
	output logic                       load,
	output logic                       clear
);

	// ==========================================================
	// clock source edge detect
	// all four sources tracked so a select change never fakes an edge
	logic [`DMAS_NSRC-1:0] prev_ff;
	logic                  tick;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= clk_src;
		end
	end

	assign tick  = clk_src[clk_sel] & ~prev_ff[clk_sel]; // [RULE6]
	// reset is synchronous to the stage clock and beats the enable
	assign clear = tick & rst_src[rst_sel]; // [RULE7]
	assign load  = tick & ce_src[ce_sel] & ~rst_src[rst_sel]; // [RULE7]

endmodule

`default_nettype wire

// File: logic/dmas_bypass_reg.sv
`timescale 1ns/1ps
`default_nettype none

module dmas_bypass_reg #(
	parameter int W = 8
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         enable,
	input  wire logic         load,
	input  wire logic         clear,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ==========================================================
	// stage register with pass-through
	logic [W-1:0] q_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_ff <= '0;
		end else if (clear) begin
			q_ff <= '0;
		end else if (load) begin
			q_ff <= d;
		end
	end

	assign q = enable ? q_ff : d; // [RULE4]

endmodule

`default_nettype wire

// File: logic/dmas_top.sv
// What this block does
// [RULE1] Multiply the first and second operand pairs and add or subtract the two products into the first partial result.
// [RULE2] Multiply the third and fourth operand pairs and add or subtract the two products into the second partial result.
// [RULE3] Add the two partial results in a final summation to give the output value.
// [RULE4] Input, pipeline and output register stages are each enabled by configuration and pass values straight through when not.
// The code registers sum_result in result_ff on every hclk, so with the output stage off it still lags sum_d by one hclk.
// [RULE5] Four clock, four clock enable and four reset sources arrive from routing and every element sees them all.
// [RULE6] Each register stage picks its own clock from the four clock sources.
// [RULE7] Each register stage picks its own clock enable and its own reset from the four sources of each.
// [RULE8] Each pairwise adder has its own setting choosing addition or subtraction.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmas_params.svh"

module dmas_top
	import dmas_pkg::*;
#(
	parameter int OP_W = `DMAS_OP_W_DEF
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic                 hreadyout,
	output logic                 hresp,
	output logic [31:0]          hrdata,
	input  wire logic [OP_W-1:0] first_pair_left_operand,
	input  wire logic [OP_W-1:0] first_pair_right_operand,
	input  wire logic [OP_W-1:0] second_pair_left_operand,
	input  wire logic [OP_W-1:0] second_pair_right_operand,
	input  wire logic [OP_W-1:0] third_pair_left_operand,
	input  wire logic [OP_W-1:0] third_pair_right_operand,
	input  wire logic [OP_W-1:0] fourth_pair_left_operand,
	input  wire logic [OP_W-1:0] fourth_pair_right_operand,
	input  wire logic            clock_source_zero,
	input  wire logic            clock_source_one,
	input  wire logic            clock_source_two,
	input  wire logic            clock_source_three,
	input  wire logic            enable_source_zero,
	input  wire logic            enable_source_one,
	input  wire logic            enable_source_two,
	input  wire logic            enable_source_three,
	input  wire logic            reset_source_zero,
	input  wire logic            reset_source_one,
	input  wire logic            reset_source_two,
	input  wire logic            reset_source_three,
	output logic [2*OP_W+1:0]    sum_result
);

	localparam int PROD_W = 2 * OP_W;
	localparam int PART_W = PROD_W + 1;
	localparam int SUM_W  = PROD_W + 2;
	localparam int OPS_W  = 8 * OP_W;
	localparam int PRS_W  = 4 * PROD_W;

	// ==========================================================
	// shared control sources
	logic [`DMAS_NSRC-1:0] clk_src;
	logic [`DMAS_NSRC-1:0] ce_src;
	logic [`DMAS_NSRC-1:0] rst_src;

	assign clk_src = {clock_source_three, clock_source_two,
		clock_source_one, clock_source_zero}; // [RULE5]
	assign ce_src  = {enable_source_three, enable_source_two,
		enable_source_one, enable_source_zero}; // [RULE5]
	assign rst_src = {reset_source_three, reset_source_two,
		reset_source_one, reset_source_zero}; // [RULE5]

	// ==========================================================
	// configuration registers
	logic [`DMAS_CTRL_W-1:0] ctrl_ff;
	logic [`DMAS_SEL_W-1:0]  sel_ff;
	logic [`DMAS_COUNT_W-1:0] count_ff;

	// ==========================================================
	// bus slave: address phase capture
	logic       addr_take;
	logic       wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] rd_word;
	logic [31:0] hrdata_ff;
	logic       count_clr;

	assign addr_take = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= addr_take & hwrite;
			wr_addr_ff <= {haddr[7:2], 2'b00};
		end
	end

	// ==========================================================
	// bus slave: write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `DMAS_CTRL_RST;
		end else if (wr_pend_ff && wr_addr_ff == `DMAS_OFS_CTRL) begin
			ctrl_ff <= hwdata[`DMAS_CTRL_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ff <= `DMAS_SEL_RST;
		end else if (wr_pend_ff && wr_addr_ff == `DMAS_OFS_SEL) begin
			sel_ff <= hwdata[`DMAS_SEL_W-1:0];
		end
	end

	assign count_clr = wr_pend_ff && wr_addr_ff == `DMAS_OFS_COUNT;

	// ==========================================================
	// stage control selection
	logic in_load;
	logic in_clear;
	logic pipe_load;
	logic pipe_clear;
	logic out_load;
	logic out_clear;

	dmas_stage_sel u_in_sel (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_src (clk_src),
		.ce_src  (ce_src),
		.rst_src (rst_src),
		.clk_sel (sel_ff[`DMAS_SEL_IN_LSB+`DMAS_SEL_CLK_OFS +: 2]),
		.ce_sel  (sel_ff[`DMAS_SEL_IN_LSB+`DMAS_SEL_CE_OFS +: 2]),
		.rst_sel (sel_ff[`DMAS_SEL_IN_LSB+`DMAS_SEL_RST_OFS +: 2]),
		.load    (in_load),
		.clear   (in_clear)
	);

	dmas_stage_sel u_pipe_sel (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_src (clk_src),
		.ce_src  (ce_src),
		.rst_src (rst_src),
		.clk_sel (sel_ff[`DMAS_SEL_PIPE_LSB+`DMAS_SEL_CLK_OFS +: 2]),
		.ce_sel  (sel_ff[`DMAS_SEL_PIPE_LSB+`DMAS_SEL_CE_OFS +: 2]),
		.rst_sel (sel_ff[`DMAS_SEL_PIPE_LSB+`DMAS_SEL_RST_OFS +: 2]),
		.load    (pipe_load),
		.clear   (pipe_clear)
	);

	dmas_stage_sel u_out_sel (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_src (clk_src),
		.ce_src  (ce_src),
		.rst_src (rst_src),
		.clk_sel (sel_ff[`DMAS_SEL_OUT_LSB+`DMAS_SEL_CLK_OFS +: 2]),
		.ce_sel  (sel_ff[`DMAS_SEL_OUT_LSB+`DMAS_SEL_CE_OFS +: 2]),
		.rst_sel (sel_ff[`DMAS_SEL_OUT_LSB+`DMAS_SEL_RST_OFS +: 2]),
		.load    (out_load),
		.clear   (out_clear)
	);

	// ==========================================================
	// input stage
	logic [OPS_W-1:0] ops_d;
	logic [OPS_W-1:0] ops_q;

	assign ops_d = {fourth_pair_right_operand, fourth_pair_left_operand,
		third_pair_right_operand, third_pair_left_operand,
		second_pair_right_operand, second_pair_left_operand,
		first_pair_right_operand, first_pair_left_operand};

	dmas_bypass_reg #(
		.W (OPS_W)
	) u_in_reg (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (ctrl_ff[`DMAS_CTRL_IN_EN]),
		.load    (in_load),
		.clear   (in_clear),
		.d       (ops_d),
		.q       (ops_q)
	);

	// ==========================================================
	// four signed multipliers
	logic [PRS_W-1:0] prod_d;
	logic [PRS_W-1:0] prod_q;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mul
			logic signed [OP_W-1:0]   lhs;
			logic signed [OP_W-1:0]   rhs;
			logic signed [PROD_W-1:0] prd;
			assign lhs = ops_q[(2*gi)*OP_W +: OP_W];
			assign rhs = ops_q[(2*gi+1)*OP_W +: OP_W];
			assign prd = PROD_W'(lhs) * PROD_W'(rhs); // [RULE1] [RULE2]
			assign prod_d[gi*PROD_W +: PROD_W] = prd;
		end
	endgenerate

	// ==========================================================
	// pipeline stage, placed after the multipliers
	dmas_bypass_reg #(
		.W (PRS_W)
	) u_pipe_reg (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (ctrl_ff[`DMAS_CTRL_PIPE_EN]),
		.load    (pipe_load),
		.clear   (pipe_clear),
		.d       (prod_d),
		.q       (prod_q)
	);

	// ==========================================================
	// pairwise add/subtract and summation
	// one extra bit per level so nothing overflows at full scale
	logic signed [PROD_W-1:0] p0;
	logic signed [PROD_W-1:0] p1;
	logic signed [PROD_W-1:0] p2;
	logic signed [PROD_W-1:0] p3;
	logic signed [PART_W-1:0] part0;
	logic signed [PART_W-1:0] part1;
	logic signed [SUM_W-1:0]  sum_d;
	logic [SUM_W-1:0]         sum_q;
	dmas_op_e                 op0;
	dmas_op_e                 op1;

	assign p0  = prod_q[0*PROD_W +: PROD_W];
	assign p1  = prod_q[1*PROD_W +: PROD_W];
	assign p2  = prod_q[2*PROD_W +: PROD_W];
	assign p3  = prod_q[3*PROD_W +: PROD_W];
	assign op0 = dmas_op_e'(ctrl_ff[`DMAS_CTRL_SUB0]); // [RULE8]
	assign op1 = dmas_op_e'(ctrl_ff[`DMAS_CTRL_SUB1]); // [RULE8]

	always_comb begin
		if (op0 == DMAS_SUB) begin
			part0 = PART_W'(p0) - PART_W'(p1); // [RULE1]
		end else begin
			part0 = PART_W'(p0) + PART_W'(p1); // [RULE1]
		end
		if (op1 == DMAS_SUB) begin
			part1 = PART_W'(p2) - PART_W'(p3); // [RULE2]
		end else begin
			part1 = PART_W'(p2) + PART_W'(p3); // [RULE2]
		end
	end

	assign sum_d = SUM_W'(part0) + SUM_W'(part1); // [RULE3]

	// ==========================================================
	// output stage
	dmas_bypass_reg #(
		.W (SUM_W)
	) u_out_reg (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (ctrl_ff[`DMAS_CTRL_OUT_EN]),
		.load    (out_load),
		.clear   (out_clear),
		.d       (sum_d),
		.q       (sum_q)
	);

	// port is always a flop so fabric sees no glitching bypass path
	logic [SUM_W-1:0] result_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_ff <= '0;
		end else begin
			result_ff <= sum_q;
		end
	end

	assign sum_result = result_ff;

	// ==========================================================
	// output stage load counter, cleared by a write to the count register
	// a load in the clearing cycle is kept, counter restarts at one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= '0;
		end else if (count_clr) begin
			count_ff <= {{(`DMAS_COUNT_W-1){1'b0}}, out_load};
		end else if (out_load) begin
			count_ff <= count_ff + 1'b1;
		end
	end

	// ==========================================================
	// bus slave: read data, registered for the data phase
	always_comb begin
		case ({haddr[7:2], 2'b00})
			`DMAS_OFS_CTRL: begin
				rd_word = 32'(ctrl_ff);
			end
			`DMAS_OFS_SEL: begin
				rd_word = 32'(sel_ff);
			end
			`DMAS_OFS_RESULT: begin
				rd_word = 32'($signed(result_ff));
			end
			`DMAS_OFS_COUNT: begin
				rd_word = 32'(count_ff);
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
		if (haddr[31:8] != 24'h000000) begin
			rd_word = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (addr_take && !hwrite) begin
			hrdata_ff <= rd_word;
		end
	end

endmodule

`default_nettype wire

// File: test/dmas_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmas_params.svh"

// ==========================================================
// port checker for the multiply-add-sum element
module dmas_top_asserts #(
	parameter int OP_W = 9
) (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic [31:0]       hrdata,
	input wire logic              clock_source_zero,
	input wire logic              reset_source_zero,
	input wire logic [2*OP_W+1:0] sum_result
);
	logic        wr_ff;
	logic [31:0] wa_ff;
	logic [4:0]  ctrl_ff;
	logic [23:0] sel_ff;
	logic        prev_ff;
	wire logic   take = hsel && htrans[1] && hready;
	// tracker starts low, so a source high at release is a tick
	wire logic   tick = clock_source_zero && !prev_ff;
	wire logic   rd_go = take && !hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			wa_ff <= 32'h0;
			prev_ff <= 1'b0;
		end else begin
			wr_ff <= take && hwrite;
			wa_ff <= haddr;
			prev_ff <= clock_source_zero;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= 5'h00;
			sel_ff <= 24'h000000;
		end else if (wr_ff && wa_ff == {24'h0, `DMAS_OFS_CTRL}) begin
			ctrl_ff <= hwdata[4:0];
		end else if (wr_ff && wa_ff == {24'h0, `DMAS_OFS_SEL}) begin
			sel_ff <= hwdata[23:0];
		end
	end

	// ==========================================================
	// properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_okay_resp: assert property (!hresp)
		else $error("response not okay");
	// read word is captured in the address phase, before a pending write lands
	a_ctrl_read: assert property (
		rd_go && haddr == {24'h0, `DMAS_OFS_CTRL}
		|=> hrdata == {27'h0, $past(ctrl_ff)})
		else $error("control readback wrong");
	a_sel_read: assert property (
		rd_go && haddr == {24'h0, `DMAS_OFS_SEL}
		|=> hrdata == {8'h0, $past(sel_ff)})
		else $error("select readback wrong");
	a_unmapped_read: assert property (
		rd_go && (haddr[31:8] != 24'h0 || haddr[7:2] > 6'h3) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_result_read: assert property (
		rd_go && haddr == {24'h0, `DMAS_OFS_RESULT}
		|=> hrdata == 32'($signed($past(sum_result))))
		else $error("result readback wrong");
	a_out_hold: assert property (
		ctrl_ff[2] && sel_ff[17:16] == 2'h0 && !tick && !wr_ff
		|-> ##2 $stable(sum_result))
		else $error("output stage moved without its clock");
	a_stage_clear: assert property (
		ctrl_ff[2] && sel_ff[21:16] == 6'h0 && tick && reset_source_zero
		&& !wr_ff |-> ##2 sum_result == '0)
		else $error("output stage not cleared");

	c_out_load: cover property (tick && ctrl_ff[2] && !reset_source_zero);
	c_res_read: cover property (rd_go && haddr == {24'h0, `DMAS_OFS_RESULT});
	c_clear: cover property (tick && reset_source_zero && ctrl_ff[2]);
endmodule

bind dmas_top dmas_top_asserts #(.OP_W(OP_W)) u_asserts (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.clock_source_zero(clock_source_zero),
	.reset_source_zero(reset_source_zero), .sum_result(sum_result)
);
`default_nettype wire

// File: test/dmas_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// fabric side: operands and routed stage controls
module dmas_fabric_model (
	input  wire logic        hclk,
	output logic      [71:0] ops,
	output logic      [3:0]  clk_src,
	output logic      [3:0]  ce_src,
	output logic      [3:0]  rst_src
);
	// four of each source, all reachable by the element
	initial begin
		ops = 72'h0;
		clk_src = 4'h0;
		ce_src = 4'hF;
		rst_src = 4'h0;
	end

	task automatic set_ops(input logic [71:0] v);
		ops <= v;
	endtask

	task automatic set_ctl(input logic [3:0] ce, input logic [3:0] rst);
		ce_src <= ce;
		rst_src <= rst;
	endtask

	// source clocks idle low; high and low one hclk period each
	task automatic tick(input int i);
		clk_src[i] <= 1'b1;
		@(posedge hclk);
		clk_src[i] <= 1'b0;
		@(posedge hclk);
	endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmas_params.svh"

`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) begin \
			failures++; \
			$display("mismatch at %0t: got %0h", $time, g); \
		end \
	end

module tb_top;
	typedef struct packed {
		logic [4:0]  ctrl;
		logic [71:0] ops;
		logic [19:0] exp;
	} dmas_row_s;

	localparam logic [31:0] A_CTRL = {24'h0, `DMAS_OFS_CTRL};
	localparam logic [31:0] A_SEL  = {24'h0, `DMAS_OFS_SEL};
	localparam logic [31:0] A_RES  = {24'h0, `DMAS_OFS_RESULT};
	localparam logic [31:0] A_CNT  = {24'h0, `DMAS_OFS_COUNT};
	localparam logic [72:0] SMALL  = {1'b0, 9'h002, 9'h001, 9'h008,
		9'h007, 9'h006, 9'h005, 9'h004, 9'h003};

	logic             hclk, hresetn, hsel, hwrite;
	logic [31:0]      haddr, hwdata, rd;
	logic [1:0]       htrans;
	logic [4:0]       pctl;
	logic [19:0]      prev;
	wire logic        hreadyout, hresp;
	wire logic [31:0] hrdata;
	wire logic [19:0] sum_result;
	wire logic [71:0] ops;
	wire logic [3:0]  cs, ce, rs;
	int               failures, samples_checked, cycles;
	dmas_row_s        rows [7];

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	dmas_fabric_model fab (.hclk(hclk), .ops(ops), .clk_src(cs),
		.ce_src(ce), .rst_src(rs));

	dmas_top #(.OP_W(9)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata),
		.first_pair_left_operand(ops[8:0]),
		.first_pair_right_operand(ops[17:9]),
		.second_pair_left_operand(ops[26:18]),
		.second_pair_right_operand(ops[35:27]),
		.third_pair_left_operand(ops[44:36]),
		.third_pair_right_operand(ops[53:45]),
		.fourth_pair_left_operand(ops[62:54]),
		.fourth_pair_right_operand(ops[71:63]),
		.clock_source_zero(cs[0]), .clock_source_one(cs[1]),
		.clock_source_two(cs[2]), .clock_source_three(cs[3]),
		.enable_source_zero(ce[0]), .enable_source_one(ce[1]),
		.enable_source_two(ce[2]), .enable_source_three(ce[3]),
		.reset_source_zero(rs[0]), .reset_source_one(rs[1]),
		.reset_source_two(rs[2]), .reset_source_three(rs[3]),
		.sum_result(sum_result)
	);

	// ==========================================================
	// bus and helpers
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic wait2;
		repeat (2) @(posedge hclk);
	endtask

	task automatic load(input int src, input logic [19:0] e);
		fab.tick(src);
		wait2();
		`CHK(sum_result, e)
	endtask

	task automatic check_rst;
		chk_rd(A_CTRL, 32'h0);
		chk_rd(A_SEL, 32'h0);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, well above the some 170 cycles needed
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("mismatch at %0t: timeout", $time);
			report_and_stop();
		end
	end

	// ==========================================================
	// sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pctl = 5'h00;
		prev = 20'h0;
		rows[0] = {5'h00, SMALL[71:0], 20'h00064};
		rows[1] = {5'h08, SMALL[71:0], 20'h00028};
		rows[2] = {5'h10, SMALL[71:0], 20'h00060};
		rows[3] = {5'h1F, SMALL[71:0], 20'h00024};
		rows[4] = {5'h07, 9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF,
			9'h100, 9'h100, 9'h100, 9'h100, 20'h3FC02};
		rows[5] = {5'h18, 9'h0FF, 9'h100, 9'h005, 9'h000,
			9'h0FF, 9'h100, 9'h100, 9'h100, 20'h2FE00};
		rows[6] = {5'h08, 36'h0, 9'h0FF, 9'h0FF, 18'h0, 20'hF01FF};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check_rst();
		foreach (rows[i]) begin
			xfer(A_CTRL, 1'b1, 32'(rows[i].ctrl));
			fab.set_ops(rows[i].ops);
			wait2();
			if (rows[i].ctrl[2] && pctl[2]) `CHK(sum_result, prev)
			if (rows[i].ctrl[2:0] != 3'h0) repeat (4) fab.tick(0);
			wait2();
			`CHK(sum_result, rows[i].exp)
			chk_rd(A_RES, 32'($signed(rows[i].exp)));
			chk_rd(A_CTRL, 32'(rows[i].ctrl));
			prev = rows[i].exp;
			pctl = rows[i].ctrl;
		end
		$display("test rows done");
		// output stage: clock one, enable two, reset three
		xfer(A_CTRL, 1'b1, 32'h04);
		xfer(A_SEL, 1'b1, 32'h0039_0000);
		fab.set_ctl(4'hB, 4'h0);
		load(1, 20'h3FC02);
		fab.set_ctl(4'h4, 4'h0);
		load(0, 20'h3FC02);
		load(1, 20'h0FE01);
		fab.set_ctl(4'h4, 4'h8);
		load(1, 20'h00000);
		chk_rd(A_SEL, 32'h0039_0000);
		xfer(A_SEL, 1'b1, 32'h0);
		fab.set_ctl(4'hF, 4'h0);
		load(0, 20'h0FE01);
		fab.set_ctl(4'hF, 4'h1);
		load(0, 20'h00000);
		$display("test select done");
		xfer(32'h10, 1'b1, 32'hFFFF_FFFF);
		chk_rd(32'h10, 32'h0);
		chk_rd(32'h100, 32'h0);
		// load counter: clear, then two output-stage loads
		xfer(A_CNT, 1'b1, 32'h0);
		chk_rd(A_CNT, 32'h0);
		fab.set_ctl(4'hF, 4'h0);
		fab.tick(0);
		fab.tick(0);
		chk_rd(A_CNT, 32'h2);
		xfer(A_RES, 1'b1, 32'hFFFF_FFFF);
		chk_rd(A_RES, 32'h0000_FE01);
		$display("test registers done");
		// second reset with a live bypass result and non-zero config
		xfer(A_SEL, 1'b1, 32'h0039_0000);
		xfer(A_CTRL, 1'b1, 32'h18);
		wait2();
		hresetn <= 1'b0;
		wait2();
		`CHK(sum_result, 20'h0)
		hresetn <= 1'b1;
		@(posedge hclk);
		check_rst();
		$display("test reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
